/* File: sss_pkg.sv */
package sss_pkg;
  // sizes
  localparam int NUM_CHAN = 8;
  localparam int CHAN_W = 3;
  localparam int GAIN_W = 2;
  localparam int EXP_CH_W = 6;
  localparam int ADC_W = 16;
  localparam int RES_BASE_W = 12;
  localparam int CAL_W = 16;
  localparam int CAL_SHIFT = 14;
  localparam int PERIOD_W = 16;
  localparam int DIO_W = 8;
  localparam int DIO_ADDR_W = 5;
  localparam int PRN_W = 8;
  localparam int PRN_CTL_W = 4;
  localparam int FIFO_AW = 4;
  localparam int SKID_AW = 1;
  localparam int SYNC_STAGES = 2;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYC = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_WAIT = CONV_CYC + SYNC_STAGES;
  localparam int MIN_PERIOD = CONV_WAIT + 4;
  localparam int STROBE_TIME_NS = 200;
  localparam int STROBE_CYC = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // reset and idle values, result limits
  localparam logic [PRN_CTL_W-1:0] PRN_CTL_IDLE = 4'hf;
  localparam logic [PRN_W-1:0] PRN_DATA_IDLE = 8'h00;
  localparam logic [ADC_W-1:0] RES_BASE_MAX = 16'h0fff;
  localparam logic [ADC_W-1:0] RES_HI_MAX = 16'hffff;

  typedef enum logic [2:0] {
    SSS_IDLE = 3'b001,
    SSS_ARMED = 3'b010,
    SSS_RUN = 3'b100
  } sss_seq_t;

  typedef enum logic [3:0] {
    SSS_DIO_IDLE = 4'b0001,
    SSS_DIO_SETUP = 4'b0010,
    SSS_DIO_STROBE = 4'b0100,
    SSS_DIO_HOLD = 4'b1000
  } sss_dio_st_t;

  // settings for one sample slot
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [GAIN_W-1:0] gain;
    logic bipolar;
    logic exp_src;
    logic [EXP_CH_W-1:0] exp_chan;
    logic filt;
    logic trig_use;
  } sss_slot_t;

  // processor access to the digital port
  typedef struct packed {
    logic write;
    logic [DIO_ADDR_W-1:0] addr;
    logic [DIO_W-1:0] wdata;
  } sss_dio_req_t;
endpackage : sss_pkg

/* File: sss_top.sv */
`timescale 1ns/10ps
module sss_fifo #(
  parameter int W = 16,
  parameter int AW = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int DEPTH = 1 << AW;
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire logic full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire logic empty = (wp_r == rp_r);
  wire logic push = in_valid_i && !full;
  wire logic pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem_r[wp_r[AW-1:0]] <= in_data_i;
  end
endmodule : sss_fifo

module sss_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic hi_res_i,
  input wire logic arm_i,
  input wire logic trig_src_ttl_i,
  input wire logic trig_falling_i,
  input wire logic [sss_pkg::PERIOD_W-1:0] period_i,
  input wire logic port_mode_byte_i,
  // processor slot loading, calibration and trigger level
  input wire logic load_i,
  input wire sss_pkg::sss_slot_t slot_i,
  input wire logic [sss_pkg::CAL_W-1:0] cal_gain_i,
  input wire logic [sss_pkg::CAL_W-1:0] cal_offset_i,
  input wire logic [sss_pkg::ADC_W-1:0] trig_level_i,
  input wire logic trig_above_i,
  // status
  output logic acq_active_o,
  output logic underrun_o,
  input wire logic underrun_clr_i,
  output logic overflow_o,
  input wire logic overflow_clr_i,
  output logic dsp_trig_o,
  // trigger pins
  input wire logic ch1_trig_i,
  input wire logic logic_trigger_in_i,
  // front end and converter
  output logic [sss_pkg::NUM_CHAN-1:0] chan_sel_o,
  output logic [sss_pkg::GAIN_W-1:0] gain_amplifier_o,
  output logic bipolar_o,
  output logic filter_sel_o,
  output logic exp_src_o,
  output logic conv_start_o,
  input wire logic [sss_pkg::ADC_W-1:0] adc_data_i,
  // expansion units
  output logic exp_strobe_o,
  output logic [sss_pkg::EXP_CH_W-1:0] exp_chan_o,
  output logic [sss_pkg::GAIN_W-1:0] exp_gain_o,
  // host sample stream
  output logic fifo_valid_o,
  input wire logic fifo_ready_i,
  output logic [sss_pkg::ADC_W-1:0] fifo_data_o,
  // processor digital port access
  input wire logic dio_req_i,
  input wire sss_pkg::sss_dio_req_t dio_cmd_i,
  output logic dio_done_o,
  output logic [sss_pkg::DIO_W-1:0] dio_rdata_o,
  // digital port pins
  input wire logic [sss_pkg::DIO_W-1:0] port_data_byte_i,
  output logic [sss_pkg::DIO_W-1:0] port_data_byte_o,
  output logic port_data_byte_oe_o,
  output logic [sss_pkg::DIO_ADDR_W-1:0] port_addr_o,
  output logic port_en_n_o,
  output logic port_rd_n_o,
  output logic port_wr_n_o,
  // printer pass-through
  input wire logic [sss_pkg::PRN_W-1:0] host_data_i,
  input wire logic [sss_pkg::PRN_CTL_W-1:0] host_ctl_i,
  output logic [sss_pkg::PRN_W-1:0] prn_data_o,
  output logic [sss_pkg::PRN_CTL_W-1:0] prn_ctl_o
);
  import sss_pkg::*;

  function automatic logic [NUM_CHAN-1:0] chan_decode(input logic [CHAN_W-1:0] c);
    chan_decode = NUM_CHAN'(1) << c;
  endfunction : chan_decode

  // pin synchronisers, first stage read only by the second
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [ADC_W-1:0] adc1_r;
  logic [ADC_W-1:0] adc2_r;
  logic [DIO_W-1:0] dio1_r;
  logic [DIO_W-1:0] dio2_r;
  logic [PRN_W+PRN_CTL_W-1:0] host1_r;
  logic [PRN_W+PRN_CTL_W-1:0] host2_r;
  logic [2:0] prime_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      adc1_r <= '0;
      adc2_r <= '0;
      dio1_r <= '0;
      dio2_r <= '0;
      host1_r <= '0;
      host2_r <= '0;
      prime_r <= '0;
    end else begin
      s1_r <= {logic_trigger_in_i, ch1_trig_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      adc1_r <= adc_data_i;
      adc2_r <= adc1_r;
      dio1_r <= port_data_byte_i;
      dio2_r <= dio1_r;
      host1_r <= {host_ctl_i, host_data_i};
      host2_r <= host1_r;
      prime_r <= {prime_r[1:0], 1'b1};
    end
  end

  // low-latency trigger edge on the selected source
  // edges masked until the synchroniser holds real pin values
  wire logic [1:0] primed = {2{prime_r[2]}};
  wire logic [1:0] rise = primed & s2_r & ~s3_r;
  wire logic [1:0] fall = primed & ~s2_r & s3_r;
  wire logic [1:0] edges = trig_falling_i ? fall : rise;
  wire logic trig_edge = trig_src_ttl_i ? edges[1] : edges[0];

  // sequencer
  sss_seq_t state_r;
  sss_seq_t state_nxt;
  logic [PERIOD_W-1:0] per_cnt_r;
  logic pend_vld_r;
  sss_slot_t pend_r;
  sss_slot_t slot_r;
  logic hires_r;
  logic [CNT_W-1:0] conv_cnt_r;
  logic conv_trig_r;
  wire logic [PERIOD_W-1:0] period_eff =
    (period_i < PERIOD_W'(MIN_PERIOD)) ? PERIOD_W'(MIN_PERIOD) : period_i;
  wire logic sample_start = ((state_r == SSS_ARMED) && trig_edge)
    || ((state_r == SSS_RUN) && (per_cnt_r == '0));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSS_IDLE: if (arm_i) state_nxt = SSS_ARMED;
      SSS_ARMED: begin
        if (!arm_i) state_nxt = SSS_IDLE;
        else if (trig_edge) state_nxt = SSS_RUN;
      end
      SSS_RUN: if (!arm_i) state_nxt = SSS_IDLE;
      default: state_nxt = SSS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= SSS_IDLE;
      per_cnt_r <= '0;
      pend_vld_r <= 1'b0;
      pend_r <= '0;
      slot_r <= '0;
      hires_r <= 1'b0;
      underrun_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      per_cnt_r <= sample_start ? period_eff - 1'b1 : per_cnt_r - (per_cnt_r != '0);
      if (load_i) pend_r <= slot_i;
      if (load_i) pend_vld_r <= 1'b1;
      else if (sample_start) pend_vld_r <= 1'b0;
      if (sample_start) begin
        slot_r <= pend_r;
        hires_r <= hi_res_i;
      end
      if (sample_start && !pend_vld_r) underrun_o <= 1'b1;
      else if (underrun_clr_i) underrun_o <= 1'b0;
    end
  end

  // applied selections, from slot_r and hires_r (loaded on the same sample_start) so they change together
  assign chan_sel_o = chan_decode(slot_r.chan);
  assign gain_amplifier_o = slot_r.gain;
  assign bipolar_o = slot_r.bipolar;
  assign exp_src_o = slot_r.exp_src;
  assign exp_chan_o = slot_r.exp_chan;
  assign exp_gain_o = slot_r.gain;
  assign filter_sel_o = slot_r.filt && hires_r;
  assign acq_active_o = (state_r == SSS_RUN);

  // conversion timing and capture
  logic raw_vld_r;
  logic [ADC_W-1:0] raw_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_start_o <= 1'b0;
      exp_strobe_o <= 1'b0;
      conv_cnt_r <= '0;
      conv_trig_r <= 1'b0;
      raw_vld_r <= 1'b0;
      raw_r <= '0;
    end else begin
      conv_start_o <= sample_start;
      exp_strobe_o <= sample_start;
      if (conv_start_o) begin
        conv_cnt_r <= CNT_W'(CONV_WAIT);
        conv_trig_r <= slot_r.trig_use;
      end else if (conv_cnt_r != '0) begin
        conv_cnt_r <= conv_cnt_r - 1'b1;
      end
      raw_vld_r <= (conv_cnt_r == CNT_W'(1));
      if (conv_cnt_r == CNT_W'(1)) begin
        raw_r <= hires_r ? adc2_r : (adc2_r & RES_BASE_MAX);
      end
    end
  end

  // gain and offset correction
  wire logic [2*CAL_W-1:0] prod = raw_r * cal_gain_i;
  wire logic [ADC_W+1:0] scaled = {2'b00, prod[CAL_SHIFT+ADC_W-1:CAL_SHIFT]};
  wire logic [ADC_W+1:0] sum = scaled + {{2{cal_offset_i[CAL_W-1]}}, cal_offset_i};
  wire logic [ADC_W-1:0] res_max = hires_r ? RES_HI_MAX : RES_BASE_MAX;
  wire logic [ADC_W-1:0] corr = sum[ADC_W+1] ? '0
    : ((sum[ADC_W] || (sum[ADC_W-1:0] > res_max)) ? res_max : sum[ADC_W-1:0]);

  logic corr_vld_r;
  logic corr_trig_r;
  logic [ADC_W-1:0] corr_r;
  logic skid_ready;
  logic mid_valid;
  logic mid_ready;
  logic [ADC_W-1:0] mid_data;
  wire logic hit = trig_above_i ? (corr_r >= trig_level_i) : (corr_r <= trig_level_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      corr_vld_r <= 1'b0;
      corr_trig_r <= 1'b0;
      corr_r <= '0;
      dsp_trig_o <= 1'b0;
      overflow_o <= 1'b0;
    end else begin
      corr_vld_r <= raw_vld_r;
      corr_trig_r <= conv_trig_r;
      if (raw_vld_r) corr_r <= corr;
      dsp_trig_o <= corr_vld_r && corr_trig_r && hit;
      if (corr_vld_r && !skid_ready) overflow_o <= 1'b1;
      else if (overflow_clr_i) overflow_o <= 1'b0;
    end
  end

  // two-entry buffer feeding the host FIFO
  sss_fifo #(.W(ADC_W), .AW(SKID_AW)) u_skid (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(corr_vld_r),
    .in_ready_o(skid_ready),
    .in_data_i(corr_r),
    .out_valid_o(mid_valid),
    .out_ready_i(mid_ready),
    .out_data_o(mid_data)
  );
  sss_fifo #(.W(ADC_W), .AW(FIFO_AW)) u_host_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(mid_valid),
    .in_ready_o(mid_ready),
    .in_data_i(mid_data),
    .out_valid_o(fifo_valid_o),
    .out_ready_i(fifo_ready_i),
    .out_data_o(fifo_data_o)
  );

  // digital port, processor side only
  sss_dio_st_t dio_r;
  sss_dio_st_t dio_nxt;
  sss_dio_req_t cmd_r;
  logic [CNT_W-1:0] dio_cnt_r;
  wire logic dio_cnt_end = (dio_cnt_r == '0);
  always_comb begin
    dio_nxt = dio_r;
    case (dio_r)
      SSS_DIO_IDLE: if (dio_req_i) dio_nxt = SSS_DIO_SETUP;
      SSS_DIO_SETUP: dio_nxt = port_mode_byte_i ? SSS_DIO_STROBE : SSS_DIO_HOLD;
      SSS_DIO_STROBE: if (dio_cnt_end) dio_nxt = SSS_DIO_HOLD;
      SSS_DIO_HOLD: dio_nxt = SSS_DIO_IDLE;
      default: dio_nxt = SSS_DIO_IDLE;
    endcase
  end
  wire logic in_strobe = (dio_r == SSS_DIO_STROBE);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dio_r <= SSS_DIO_IDLE;
      cmd_r <= '0;
      dio_cnt_r <= '0;
      dio_done_o <= 1'b0;
      dio_rdata_o <= '0;
      port_addr_o <= '0;
      port_data_byte_o <= '0;
      port_data_byte_oe_o <= 1'b0;
      port_en_n_o <= 1'b1;
      port_rd_n_o <= 1'b1;
      port_wr_n_o <= 1'b1;
    end else begin
      dio_r <= dio_nxt;
      if (dio_r == SSS_DIO_IDLE && dio_req_i) cmd_r <= dio_cmd_i;
      dio_cnt_r <= (dio_r == SSS_DIO_SETUP) ? CNT_W'(STROBE_CYC - 1) : dio_cnt_r - !dio_cnt_end;
      dio_done_o <= (dio_r == SSS_DIO_HOLD);
      if ((in_strobe && dio_cnt_end && !cmd_r.write) || (dio_r == SSS_DIO_SETUP && !port_mode_byte_i))
        dio_rdata_o <= dio2_r;
      port_addr_o <= port_mode_byte_i ? cmd_r.addr : '0;
      port_en_n_o <= !(port_mode_byte_i && (dio_nxt != SSS_DIO_IDLE) && (dio_r != SSS_DIO_IDLE));
      port_rd_n_o <= !((dio_nxt == SSS_DIO_STROBE) && !cmd_r.write);
      port_wr_n_o <= !((dio_nxt == SSS_DIO_STROBE) && cmd_r.write);
      port_data_byte_oe_o <= port_mode_byte_i && cmd_r.write && (dio_nxt != SSS_DIO_IDLE)
        && (dio_r != SSS_DIO_IDLE);
      port_data_byte_o <= cmd_r.wdata;
    end
  end

  // printer pass-through
  wire logic unit_active = (state_r != SSS_IDLE);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prn_data_o <= PRN_DATA_IDLE;
      prn_ctl_o <= PRN_CTL_IDLE;
    end else begin
      prn_data_o <= unit_active ? PRN_DATA_IDLE : host2_r[PRN_W-1:0];
      prn_ctl_o <= unit_active ? PRN_CTL_IDLE : host2_r[PRN_W+PRN_CTL_W-1:PRN_W];
    end
  end

  // checks
  localparam int CW = CONV_WAIT + 1;
  one_hot_chan_a: assert property (@(posedge clk_i) disable iff (rst_i) $onehot(chan_sel_o))
    else $error("channel select not one-hot");
  conv_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_start_o |-> ##CW raw_vld_r) else $error("capture not at conversion end");
  base_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (corr_vld_r && !hires_r) |-> (corr_r[ADC_W-1:RES_BASE_W] == '0)) else $error("base result too wide");
  apply_together_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_start |=> (chan_sel_o == chan_decode($past(pend_r.chan))) && (bipolar_o == $past(pend_r.bipolar))
    && (exp_src_o == $past(pend_r.exp_src))) else $error("settings not applied together");
  exp_forward_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_start |=> exp_strobe_o && conv_start_o && (exp_gain_o == $past(pend_r.gain))
    && (exp_chan_o == $past(pend_r.exp_chan)))
    else $error("expansion not told at sample start");
  filter_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_start |=> (filter_sel_o == ($past(pend_r.filt) && $past(hi_res_i))))
    else $error("filter select wrong for variant");
  overflow_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (corr_vld_r && !skid_ready) |=> overflow_o) else $error("overflow not flagged");
  underrun_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_start && !pend_vld_r) |=> underrun_o) else $error("underrun not flagged");
  trig_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_r == SSS_ARMED) && arm_i && trig_edge) |=> acq_active_o && conv_start_o)
    else $error("trigger did not start acquisition");
  printer_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    unit_active |=> (prn_ctl_o == PRN_CTL_IDLE)) else $error("printer not held idle");
  strobe_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!port_rd_n_o || !port_wr_n_o) |-> !port_en_n_o) else $error("strobe without enable");
  cov_run_c: cover property (@(posedge clk_i) disable iff (rst_i) conv_start_o ##[40:60] corr_vld_r);
  cov_trig_c: cover property (@(posedge clk_i) disable iff (rst_i) dsp_trig_o);
  cov_ovf_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(overflow_o));
  cov_dio_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(port_wr_n_o));
endmodule : sss_top

/* File: sss_dsp_model.sv */
`timescale 1ns/10ps
module sss_dsp_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench commands
  input wire logic kick_i,
  input wire logic skip_i,
  input wire logic start_i,
  input wire sss_pkg::sss_slot_t next_i,
  // slot loading
  output logic load_o,
  output sss_pkg::sss_slot_t slot_o
);
  import sss_pkg::*;
  logic [1:0] dly_r;
  logic go;
  // reload three cycles after each start, well ahead of the next one
  assign go = kick_i | (dly_r[1] & ~skip_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly_r <= 2'h0;
      load_o <= 1'h0;
      slot_o <= '0;
    end else begin
      dly_r <= {dly_r[0], start_i};
      load_o <= go;
      // slot bus is garbage whenever no load is offered
      slot_o <= go ? next_i : ~next_i;
    end
  end
endmodule : sss_dsp_model

/* File: testbench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
`define WAIT(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin tick(1); k++; end \
  if (!(c)) begin fail_count++; give_verdict(); end end
module testbench;
  import sss_pkg::*;
  localparam logic [7:0] HR = 8'hb0;
  localparam logic [15:0] CG [8] = '{16'h4000, 16'h2000, 16'h4000, 16'h4000,
    16'h4000, 16'h2000, 16'h4000, 16'h4000};
  localparam logic [15:0] CO [8] = '{16'h0, 16'h0, 16'h10, 16'h10, 16'h0, 16'h0, 16'h0, 16'h0};
  localparam logic [15:0] AD [8] = '{16'h0ffe, 16'h0246, 16'h0246, 16'h0ffe,
    16'hfff0, 16'h0100, 16'h0001, 16'h7ffe};
  localparam logic [15:0] EX [8] = '{16'h0ffe, 16'h0123, 16'h0256, 16'h0fff,
    16'hfff0, 16'h0080, 16'h0001, 16'h7ffe};
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic hi_res_i = 1'h0, arm_i = 1'h0, trig_src_ttl_i = 1'h0, trig_falling_i = 1'h0;
  logic port_mode_byte_i = 1'h1, trig_above_i = 1'h1, underrun_clr_i = 1'h0;
  logic overflow_clr_i = 1'h0, ch1_trig_i = 1'h0, logic_trigger_in_i = 1'h1;
  logic fifo_ready_i = 1'h0, dio_req_i = 1'h0, kick = 1'h0, skip = 1'h0, load_i;
  logic [15:0] period_i = 16'h0064, cal_gain_i = 16'h4000, cal_offset_i = 16'h0;
  logic [15:0] trig_level_i = 16'h0200, adc_data_i = 16'h0, fifo_data_o;
  logic [7:0] pin_val = 8'h8c, host_data_i = 8'h5a, port_data_byte_i, port_data_byte_o;
  logic [7:0] dio_rdata_o, prn_data_o, chan_sel_o;
  logic [3:0] host_ctl_i = 4'h6, prn_ctl_o;
  logic [4:0] port_addr_o;
  logic [5:0] exp_chan_o;
  logic [1:0] gain_amplifier_o, exp_gain_o;
  logic acq_active_o, underrun_o, overflow_o, dsp_trig_o, bipolar_o, filter_sel_o;
  logic exp_src_o, conv_start_o, exp_strobe_o, fifo_valid_o, dio_done_o;
  logic port_data_byte_oe_o, port_en_n_o, port_rd_n_o, port_wr_n_o;
  sss_slot_t slot_i, cur, next_slot = '0;
  sss_dio_req_t dio_cmd_i = '0;
  int fail_count = 0, compares = 0, trig_cnt = 0, strb = 0, pops = 0, p0;
  time tp;

  sss_dsp_model u_dsp (.clk_i, .rst_i, .kick_i(kick), .skip_i(skip), .start_i(conv_start_o),
    .next_i(next_slot), .load_o(load_i), .slot_o(slot_i));
  sss_top DUT (.clk_i, .rst_i, .hi_res_i, .arm_i, .trig_src_ttl_i, .trig_falling_i, .period_i,
    .port_mode_byte_i, .load_i, .slot_i, .cal_gain_i, .cal_offset_i, .trig_level_i,
    .trig_above_i, .acq_active_o, .underrun_o, .underrun_clr_i, .overflow_o, .overflow_clr_i,
    .dsp_trig_o, .ch1_trig_i, .logic_trigger_in_i, .chan_sel_o, .gain_amplifier_o, .bipolar_o,
    .filter_sel_o, .exp_src_o, .conv_start_o, .adc_data_i, .exp_strobe_o, .exp_chan_o,
    .exp_gain_o, .fifo_valid_o, .fifo_ready_i, .fifo_data_o, .dio_req_i, .dio_cmd_i,
    .dio_done_o, .dio_rdata_o, .port_data_byte_i, .port_data_byte_o, .port_data_byte_oe_o,
    .port_addr_o, .port_en_n_o, .port_rd_n_o, .port_wr_n_o, .host_data_i, .host_ctl_i,
    .prn_data_o, .prn_ctl_o);

  // external byte device answers while read strobe is low; outside byte mode pin_val is always driven
  assign port_data_byte_i = port_data_byte_oe_o ? port_data_byte_o :
    (!port_rd_n_o || !port_mode_byte_i) ? pin_val : ~pin_val;

  always #12.5 clk_i = ~clk_i;

  always @(negedge clk_i) begin
    if (!port_rd_n_o || !port_wr_n_o) begin
      strb++;
      `CHK({port_en_n_o, port_addr_o, port_wr_n_o},
        {1'h0, dio_cmd_i.addr, !dio_cmd_i.write})
      if (dio_cmd_i.write) `CHK({port_data_byte_oe_o, port_data_byte_o},
        {1'h1, dio_cmd_i.wdata})
    end
    if (dsp_trig_o === 1'h1) trig_cnt++;
    if (fifo_valid_o === 1'h1 && fifo_ready_i === 1'h1) pops++;
  end

  task tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #2;
    end
  endtask : tick

  task automatic dio(input sss_dio_req_t c, input int cyc, input int low);
    time t0;
    int s0;
    s0 = strb;
    dio_cmd_i = c;
    dio_req_i = 1'h1;
    t0 = $time;
    tick(1);
    dio_req_i = 1'h0;
    `WAIT(dio_done_o, 40)
    `CHK(($time - t0) / CLK_PERIOD_NS, cyc)
    `CHK(strb - s0, low)
  endtask : dio

  function automatic sss_slot_t mk(input int i);
    sss_slot_t s;
    s.chan = i[2:0];
    s.gain = i[1:0];
    s.bipolar = i[2] & i[0];
    s.exp_src = i[0];
    s.exp_chan = 6'(i * 9);
    s.filt = 1'h1;
    s.trig_use = (i == 4) || (i == 5);
    return s;
  endfunction : mk

  task kick_load;
    kick = 1'h1;
    tick(1);
    kick = 1'h0;
  endtask : kick_load

  task give_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (12) @(posedge clk_i);
    #2;
    rst_i = 1'h0;
    `CHK(chan_sel_o, 8'h01)
    `CHK({prn_ctl_o, prn_data_o}, 12'hf00)
    `CHK({port_en_n_o, port_rd_n_o, port_wr_n_o, port_data_byte_oe_o}, 4'he)
    `CHK(fifo_valid_o, 1'h0)
    tick(4);
    `CHK({prn_ctl_o, prn_data_o}, 12'h65a)
    $display("test reset done");
    dio('{1'h1, 5'h1f, 8'hc3}, 11, 8);
    dio('{1'h0, 5'h01, 8'h00}, 11, 8);
    `CHK(dio_rdata_o, 8'h8c)
    port_mode_byte_i = 1'h0;
    pin_val = 8'h3e;
    tick(2);
    dio('{1'h0, 5'h00, 8'h00}, 3, 0);
    `CHK(dio_rdata_o, 8'h3e)
    $display("test port done");
    next_slot = mk(0);
    kick_load();
    arm_i = 1'h1;
    tick(2);
    for (int i = 0; i < 8; i++) begin
      hi_res_i = HR[i];
      cal_gain_i = CG[i];
      cal_offset_i = CO[i];
      adc_data_i = AD[i];
      ch1_trig_i = 1'h1;
      trig_above_i = (i != 5);
      cur = mk(i);
      `WAIT(conv_start_o, 200)
      if (i > 0) `CHK($time - tp, 100 * CLK_PERIOD_NS)
      tp = $time;
      next_slot = mk(i + 1);
      `CHK({exp_strobe_o, acq_active_o}, 2'h3)
      `CHK(chan_sel_o, 8'h01 << i)
      `CHK({gain_amplifier_o, bipolar_o, exp_src_o},
        {cur.gain, cur.bipolar, cur.exp_src})
      `CHK({exp_chan_o, exp_gain_o}, {cur.exp_chan, cur.gain})
      `CHK(filter_sel_o, HR[i])
      `WAIT(fifo_valid_o, 120)
      `CHK(fifo_data_o, EX[i])
      fifo_ready_i = 1'h1;
      tick(1);
      fifo_ready_i = 1'h0;
    end
    `CHK(trig_cnt, 2)
    $display("test sequence done");
    skip = 1'h1;
    `WAIT(conv_start_o, 200)
    tick(1);
    `CHK(underrun_o, 1'h0)
    `WAIT(conv_start_o, 200)
    tick(1);
    `CHK({underrun_o, chan_sel_o}, 9'h101)
    underrun_clr_i = 1'h1;
    tick(1);
    underrun_clr_i = 1'h0;
    `CHK(underrun_o, 1'h0)
    $display("test underrun done");
    skip = 1'h0;
    period_i = 16'h0000;
    `WAIT(conv_start_o, 200)
    tick(1);
    `WAIT(conv_start_o, 200)
    tp = $time;
    tick(1);
    `WAIT(conv_start_o, 200)
    `CHK($time - tp, 46 * CLK_PERIOD_NS)
    `WAIT(overflow_o, 1500)
    arm_i = 1'h0;
    tick(60);
    p0 = pops;
    fifo_ready_i = 1'h1;
    `WAIT(fifo_valid_o !== 1'h1, 40)
    fifo_ready_i = 1'h0;
    `CHK(pops - p0, 18)
    `CHK({overflow_o, acq_active_o, prn_data_o}, 10'h25a)
    overflow_clr_i = 1'h1;
    tick(1);
    overflow_clr_i = 1'h0;
    `CHK(overflow_o, 1'h0)
    $display("test overflow done");
    trig_src_ttl_i = 1'h1;
    trig_falling_i = 1'h1;
    period_i = 16'h0064;
    kick_load();
    arm_i = 1'h1;
    tick(4);
    `CHK({prn_ctl_o, prn_data_o}, 12'hf00)
    ch1_trig_i = 1'h0;
    tick(10);
    `CHK(acq_active_o, 1'h0)
    logic_trigger_in_i = 1'h0;
    `WAIT(conv_start_o, 20)
    `CHK(acq_active_o, 1'h1)
    arm_i = 1'h0;
    $display("test trigger done");
    give_verdict();
  end
endmodule : testbench
